// file: bench/tcc_core_model.sv
// far-side model: timer 2 counter core and compare pin wires
`timescale 1ns/10ps

module tcc_core_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire tcc_pkg::tcc_pin_t pin_a,
    input wire tcc_pkg::tcc_pin_t pin_b,
    output logic [15:0] count,
    output logic wire_a,
    output logic wire_b
);
    import tcc_pkg::*;

    // ****************************************
    // counter core: holds still, software writes overwrite it
    // ****************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= 16'h0000;
        else if (load)
            count <= load_value;
    end

    // released pins fall to their pull-down level
    assign wire_a = pin_a.oe_b ? 1'b0 : pin_a.out;
    assign wire_b = pin_b.oe_b ? 1'b0 : pin_b.out;
endmodule : tcc_core_model

// file: bench/tcc_top_tb.sv
// self-checking bench for the timer 2 capture/compare block
`timescale 1ns/10ps
`include "tcc_params.svh"

module tcc_top_tb;
    import tcc_pkg::*;

    localparam int FILT = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    tcc_bus_req_t bus_req = '0;
    logic [15:0] bus_rdata;
    logic [15:0] t2_count;
    logic cnt_load;
    logic [15:0] cnt_load_value;
    tcc_core_evt_t core_evt = '0;
    logic [6:0] t1_evt = 7'h00;
    logic [1:0] cap_in = 2'b00;
    tcc_pin_t pin_a;
    tcc_pin_t pin_b;
    logic wire_a;
    logic wire_b;
    logic irq;
    int bad_count = 0;
    int cmp_count = 0;
    int ev_bits [10] = '{0, 1, 2, 3, 4, 5, 6, 8, 11, 12};
    logic [15:0] reg_off [9] = '{`TCC_OFF_CAPA, `TCC_OFF_CAPB, `TCC_OFF_CMPA, `TCC_OFF_CMPB, `TCC_OFF_CMPCFGA,
        `TCC_OFF_CMPCFGB, `TCC_OFF_CAPCFGA, `TCC_OFF_CAPCFGB, `TCC_OFF_IRQ_EN};
    logic [15:0] reg_msk [9] = '{16'h0000, 16'h0000, 16'hffff, 16'hffff, 16'h801f, 16'h801f, 16'h0160, 16'h0160,
        16'h7f7f};

    always #2.5 clk = ~clk;

    tcc_top #(.FILT_LEN(FILT)) i_tcc_top (.CLK(clk), .RST_B(rst_b), .BUS_REQ(bus_req), .BUS_RDATA(bus_rdata),
        .T2_COUNT(t2_count), .T2_COUNT_LOAD(cnt_load), .T2_COUNT_LOAD_VALUE(cnt_load_value),
        .T2_CORE_EVENTS(core_evt), .T1_EVENTS(t1_evt), .CAPA_IN(cap_in[0]), .CAPB_IN(cap_in[1]),
        .CMPA_PIN(pin_a), .CMPB_PIN(pin_b), .IRQ(irq));

    tcc_core_model i_tcc_core_model (.clk(clk), .rst_b(rst_b), .load(cnt_load), .load_value(cnt_load_value),
        .pin_a(pin_a), .pin_b(pin_b), .count(t2_count), .wire_a(wire_a), .wire_b(wire_b));

    // ****************************************
    // compare and bus tasks
    // ****************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk16(bus_rdata, exp);
    endtask : bus_rd

    task automatic load_cnt(input logic [15:0] v);
        bus_wr(`TCC_OFF_T2_COUNT, v);
        repeat (2) @(posedge clk);
    endtask : load_cnt

    task automatic evt_pulse(input int b);
        @(posedge clk);
        if (b < 7)
            t1_evt <= 7'(1 << b);
        else
            core_evt <= (b == 8) ? 3'b001 : (b == 11) ? 3'b010 : 3'b100;
        @(posedge clk);
        t1_evt <= 7'h00;
        core_evt <= '0;
        repeat (2) @(posedge clk);
    endtask : evt_pulse

    task automatic cmp_case(input int ch, input logic [15:0] cfg, input logic exp_wire, input logic exp_oe_b);
        logic [15:0] thr;
        thr = 16'h0010 << ch;
        bus_wr(`TCC_OFF_CMPCFGA + 16'(2 * ch), cfg);
        load_cnt(thr - 16'h0001);
        load_cnt(thr);
        #1;
        chk1(ch ? wire_b : wire_a, exp_wire);
        chk1(ch ? pin_b.oe_b : pin_a.oe_b, exp_oe_b);
        bus_rd(`TCC_OFF_IRQ_FLAG, 16'h0200 << ch);
        bus_wr(`TCC_OFF_IRQ_FLAG, 16'h0200 << ch);
    endtask : cmp_case

    task automatic cap_case(input int ch, input logic [15:0] cfg, input logic [15:0] cnt, input logic lvl,
        input int hold, input logic pulse, input logic [15:0] exp, input logic [15:0] exp_flag);
        bus_wr(`TCC_OFF_CAPCFGA + 16'(2 * ch), cfg);
        load_cnt(cnt);
        @(posedge clk);
        cap_in[ch] <= lvl;
        repeat (hold) @(posedge clk);
        if (pulse)
            cap_in[ch] <= ~lvl;
        repeat (FILT + 4) @(posedge clk);
        bus_rd(`TCC_OFF_CAPA + 16'(2 * ch), exp);
        bus_rd(`TCC_OFF_IRQ_FLAG, exp_flag << ch);
        chk1(irq, |exp_flag);
        bus_wr(`TCC_OFF_IRQ_FLAG, 16'h6000);
    endtask : cap_case

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        #100000;
        bad_count++;
        end_sim();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        chk1(pin_a.oe_b, 1'b1);
        chk1(irq, 1'b0);
        rst_b <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            bus_rd(reg_off[i], 16'h0000);
            bus_wr(reg_off[i], 16'hffff);
            bus_rd(reg_off[i], reg_msk[i]);
            bus_wr(reg_off[i], 16'h0000);
        end
        bus_wr(16'h4586, 16'hffff);
        bus_rd(16'h4586, 16'h0000);
        load_cnt(16'hbeef);
        bus_rd(`TCC_OFF_T2_COUNT, 16'hbeef);
        $display("test registers done");

        foreach (ev_bits[i])
        begin
            evt_pulse(ev_bits[i]);
            bus_rd(`TCC_OFF_IRQ_FLAG, 16'h0001 << ev_bits[i]);
            bus_wr(`TCC_OFF_IRQ_EN, 16'h7f7f ^ (16'h0001 << ev_bits[i]));
            #1 chk1(irq, 1'b0);
            bus_wr(`TCC_OFF_IRQ_EN, 16'h0001 << ev_bits[i]);
            #1 chk1(irq, 1'b1);
            bus_wr(`TCC_OFF_IRQ_FLAG, 16'h0001 << ev_bits[i]);
            #1 chk1(irq, 1'b0);
            evt_pulse(ev_bits[i]);
            chk1(irq, 1'b1);
            bus_wr(`TCC_OFF_IRQ_FLAG, 16'h0001 << ev_bits[i]);
            bus_wr(`TCC_OFF_IRQ_EN, 16'h0000);
        end
        $display("test events done");

        bus_wr(`TCC_OFF_CMPA, 16'h0010);
        bus_wr(`TCC_OFF_CMPB, 16'h0020);
        bus_rd(`TCC_OFF_CMPB, 16'h0020);
        cmp_case(0, 16'h8001, 1'b1, 1'b0);
        cmp_case(0, 16'h8002, 1'b0, 1'b0);
        cmp_case(0, 16'h8003, 1'b1, 1'b0);
        cmp_case(0, 16'h8003, 1'b0, 1'b0);
        cmp_case(0, 16'h8011, 1'b0, 1'b0);
        cmp_case(1, 16'h8000, 1'b0, 1'b0);
        cmp_case(1, 16'h0001, 1'b0, 1'b1);
        cmp_case(1, 16'h8003, 1'b0, 1'b0);
        $display("test compare done");

        bus_wr(`TCC_OFF_IRQ_EN, 16'h6000);
        cap_case(0, 16'h0020, 16'h1234, 1'b1, 1, 1'b0, 16'h1234, 16'h2000);
        cap_case(0, 16'h0020, 16'h2222, 1'b0, 1, 1'b0, 16'h1234, 16'h0000);
        cap_case(0, 16'h0040, 16'h3333, 1'b1, 1, 1'b0, 16'h1234, 16'h0000);
        cap_case(0, 16'h0040, 16'h3344, 1'b0, 1, 1'b0, 16'h3344, 16'h2000);
        cap_case(0, 16'h0060, 16'h4444, 1'b1, 1, 1'b0, 16'h4444, 16'h2000);
        cap_case(0, 16'h0000, 16'h5555, 1'b0, 1, 1'b0, 16'h4444, 16'h0000);
        cap_case(0, 16'h0120, 16'h6666, 1'b1, 2, 1'b1, 16'h4444, 16'h0000);
        cap_case(0, 16'h0120, 16'h6677, 1'b1, 10, 1'b0, 16'h6677, 16'h2000);
        cap_case(0, 16'h0060, 16'h4455, 1'b0, 1, 1'b0, 16'h4455, 16'h2000);
        cap_case(1, 16'h0060, 16'h7777, 1'b1, 1, 1'b0, 16'h7777, 16'h2000);
        bus_wr(`TCC_OFF_CAPB, 16'h0000);
        bus_rd(`TCC_OFF_CAPB, 16'h7777);
        $display("test capture done");
        end_sim();
    end
endmodule : tcc_top_tb

// file: verilog/tcc_capture.sv
// one capture channel: optional input filter, edge select and count latch
`timescale 1ns/10ps
`include "tcc_params.svh"

module tcc_capture #(
    parameter int FILT_LEN = `TCC_FILT_LEN_DEF
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    input wire tcc_pkg::tcc_cap_cfg_t cfg,
    input wire logic [`TCC_DW-1:0] count,
    output logic [`TCC_DW-1:0] value,
    output logic event_pulse
);
    import tcc_pkg::*;

    if (FILT_LEN < `TCC_FILT_LEN_MIN || FILT_LEN > `TCC_FILT_LEN_MAX)
    begin : g_bad_len
        $error("tcc_capture: FILT_LEN out of range");
    end

    // ****************************************
    // edge qualification
    // ****************************************
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        edge_hit = ((sel == TCC_EDGE_RISE) && rise) || ((sel == TCC_EDGE_FALL) && fall) ||
                   ((sel == TCC_EDGE_BOTH) && (rise || fall));
    endfunction : edge_hit

    logic [FILT_LEN-1:0] hist;
    logic filt_level;
    logic prev_level;

    wire all_high = &hist;
    wire all_low = ~|hist;
    // filtered level moves only after FILT_LEN equal samples
    wire next_filt_level = all_high ? 1'b1 : (all_low ? 1'b0 : filt_level);
    wire level = cfg.filt ? filt_level : pin;
    wire rise = level && !prev_level;
    wire fall = !level && prev_level;
    wire hit = edge_hit(cfg.edge_sel, rise, fall);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hist <= '0;
            filt_level <= 1'b0;
            prev_level <= 1'b0;
            value <= `TCC_RST_WORD;
            event_pulse <= 1'b0;
        end
        else
        begin
            hist <= {hist[FILT_LEN-2:0], pin};
            filt_level <= next_filt_level;
            prev_level <= level;
            value <= hit ? count : value;
            event_pulse <= hit;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_capture_value_load: assert property (@(posedge clk) disable iff (!rst_b)
        hit |=> (value == $past(count)) && event_pulse)
        else $error("capture did not record the count");

    a_capture_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg.edge_sel == TCC_EDGE_OFF) |=> !event_pulse)
        else $error("capture fired while disabled");

    a_filter_holds_level: assert property (@(posedge clk) disable iff (!rst_b)
        (!all_high && !all_low) |=> (filt_level == $past(filt_level)))
        else $error("filter moved on a mixed sample history");

endmodule : tcc_capture

// file: verilog/tcc_params.svh
// named offsets, bit positions, reset values and counts for the timer capture/compare block
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// ****************************************
// data width, reset word and event mask
// ****************************************
`define TCC_DW 16
`define TCC_RST_WORD 16'h0000
`define TCC_EVT_MASK 16'h7f7f

// ****************************************
// register offsets
// ****************************************
`define TCC_OFF_T2_COUNT 16'h4580
`define TCC_OFF_CAPA 16'h4582
`define TCC_OFF_CAPB 16'h4584
`define TCC_OFF_CMPA 16'h4588
`define TCC_OFF_CMPB 16'h458a
`define TCC_OFF_CMPCFGA 16'h458e
`define TCC_OFF_CMPCFGB 16'h4590
`define TCC_OFF_CAPCFGA 16'h4592
`define TCC_OFF_CAPCFGB 16'h4594
`define TCC_OFF_IRQ_FLAG 16'h4614
`define TCC_OFF_IRQ_EN 16'h462c

// ****************************************
// field positions
// ****************************************
`define TCC_CMP_EN_BIT 15
`define TCC_CMP_INV_BIT 4
`define TCC_CMP_MODE_HI 3
`define TCC_CMP_MODE_LO 0
`define TCC_CAP_FILT_BIT 8
`define TCC_CAP_EDGE_HI 6
`define TCC_CAP_EDGE_LO 5
`define TCC_T1_EVT_HI 6
`define TCC_T1_EVT_LO 0
`define TCC_T2_EVT_HI 14
`define TCC_T2_EVT_LO 8

// ****************************************
// event positions inside one timer group
// ****************************************
`define TCC_EV_OVF 0
`define TCC_EV_CMPA 1
`define TCC_EV_CMPB 2
`define TCC_EV_ZERO 3
`define TCC_EV_TOP 4
`define TCC_EV_CAPA 5
`define TCC_EV_CAPB 6

// ****************************************
// capture input filter
// ****************************************
`define TCC_FILT_LEN_DEF 4
`define TCC_FILT_LEN_MIN 2
`define TCC_FILT_LEN_MAX 16

`endif

// file: verilog/tcc_pkg.sv
// types shared by the timer capture/compare block
package tcc_pkg;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        TCC_EDGE_OFF = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_FALL = 2'h2,
        TCC_EDGE_BOTH = 2'h3
    } tcc_edge_t;

    typedef enum logic [3:0] {
        TCC_MODE_HOLD = 4'h0,
        TCC_MODE_SET = 4'h1,
        TCC_MODE_CLEAR = 4'h2,
        TCC_MODE_TOGGLE = 4'h3
    } tcc_mode_t;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic en;
        logic inv;
        logic [3:0] mode;
    } tcc_cmp_cfg_t;

    typedef struct packed {
        logic filt;
        logic [1:0] edge_sel;
    } tcc_cap_cfg_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tcc_bus_req_t;

    typedef struct packed {
        logic top;
        logic zero;
        logic overflow;
    } tcc_core_evt_t;

    typedef struct packed {
        logic out;
        logic oe_b;
    } tcc_pin_t;

endpackage : tcc_pkg

// file: verilog/tcc_top.sv
// timer 2 capture/compare registers, compare outputs, capture inputs and shared event enables
// ****************************************
// ****************************************
`timescale 1ns/10ps
`include "tcc_params.svh"

module tcc_top #(
    parameter int FILT_LEN = `TCC_FILT_LEN_DEF
)
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire tcc_pkg::tcc_bus_req_t BUS_REQ,
    output logic [`TCC_DW-1:0] BUS_RDATA,
    input wire logic [`TCC_DW-1:0] T2_COUNT,
    output logic T2_COUNT_LOAD,
    output logic [`TCC_DW-1:0] T2_COUNT_LOAD_VALUE,
    input wire tcc_pkg::tcc_core_evt_t T2_CORE_EVENTS,
    input wire logic [`TCC_T1_EVT_HI:`TCC_T1_EVT_LO] T1_EVENTS,
    input wire logic CAPA_IN,
    input wire logic CAPB_IN,
    output tcc_pkg::tcc_pin_t CMPA_PIN,
    output tcc_pkg::tcc_pin_t CMPB_PIN,
    output logic IRQ
);
    import tcc_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic tcc_cmp_cfg_t cmp_cfg_of(input logic [`TCC_DW-1:0] w);
        cmp_cfg_of.en = w[`TCC_CMP_EN_BIT];
        cmp_cfg_of.inv = w[`TCC_CMP_INV_BIT];
        cmp_cfg_of.mode = w[`TCC_CMP_MODE_HI:`TCC_CMP_MODE_LO];
    endfunction : cmp_cfg_of

    function automatic logic [`TCC_DW-1:0] cmp_word(input tcc_cmp_cfg_t c);
        cmp_word = `TCC_RST_WORD;
        cmp_word[`TCC_CMP_EN_BIT] = c.en;
        cmp_word[`TCC_CMP_INV_BIT] = c.inv;
        cmp_word[`TCC_CMP_MODE_HI:`TCC_CMP_MODE_LO] = c.mode;
    endfunction : cmp_word

    function automatic tcc_cap_cfg_t cap_cfg_of(input logic [`TCC_DW-1:0] w);
        cap_cfg_of.filt = w[`TCC_CAP_FILT_BIT];
        cap_cfg_of.edge_sel = w[`TCC_CAP_EDGE_HI:`TCC_CAP_EDGE_LO];
    endfunction : cap_cfg_of

    function automatic logic [`TCC_DW-1:0] cap_word(input tcc_cap_cfg_t c);
        cap_word = `TCC_RST_WORD;
        cap_word[`TCC_CAP_FILT_BIT] = c.filt;
        cap_word[`TCC_CAP_EDGE_HI:`TCC_CAP_EDGE_LO] = c.edge_sel;
    endfunction : cap_word

    // match fires once, on the cycle the count arrives at the threshold
    function automatic logic cmp_hit(input logic [`TCC_DW-1:0] cnt, input logic [`TCC_DW-1:0] prev,
                                     input logic [`TCC_DW-1:0] thr);
        cmp_hit = (cnt == thr) && (cnt != prev);
    endfunction : cmp_hit

    function automatic logic next_level(input logic [3:0] mode, input logic lev, input logic hit);
        case (mode)
            TCC_MODE_SET: next_level = hit ? 1'b1 : lev;
            TCC_MODE_CLEAR: next_level = hit ? 1'b0 : lev;
            TCC_MODE_TOGGLE: next_level = hit ? !lev : lev;
            default: next_level = lev;
        endcase
    endfunction : next_level

    // ****************************************
    // registers
    // ****************************************
    logic [`TCC_DW-1:0] cmp_thr_a;
    logic [`TCC_DW-1:0] cmp_thr_b;
    tcc_cmp_cfg_t cmp_cfg_a;
    tcc_cmp_cfg_t cmp_cfg_b;
    tcc_cap_cfg_t cap_cfg_a;
    tcc_cap_cfg_t cap_cfg_b;
    logic [`TCC_DW-1:0] irq_en;
    logic [`TCC_DW-1:0] irq_flag;
    logic [`TCC_DW-1:0] prev_count;
    logic lev_a;
    logic lev_b;
    logic [`TCC_DW-1:0] cap_val_a;
    logic [`TCC_DW-1:0] cap_val_b;
    logic capa_evt;
    logic capb_evt;

    // ****************************************
    // address decode
    // ****************************************
    wire wr = BUS_REQ.wr;
    wire [`TCC_DW-1:0] wd = BUS_REQ.wdata;
    wire sel_cnt = BUS_REQ.addr == `TCC_OFF_T2_COUNT;
    wire sel_capa = BUS_REQ.addr == `TCC_OFF_CAPA;
    wire sel_capb = BUS_REQ.addr == `TCC_OFF_CAPB;
    wire sel_cmpa = BUS_REQ.addr == `TCC_OFF_CMPA;
    wire sel_cmpb = BUS_REQ.addr == `TCC_OFF_CMPB;
    wire sel_cmpcfga = BUS_REQ.addr == `TCC_OFF_CMPCFGA;
    wire sel_cmpcfgb = BUS_REQ.addr == `TCC_OFF_CMPCFGB;
    wire sel_capcfga = BUS_REQ.addr == `TCC_OFF_CAPCFGA;
    wire sel_capcfgb = BUS_REQ.addr == `TCC_OFF_CAPCFGB;
    wire sel_flag = BUS_REQ.addr == `TCC_OFF_IRQ_FLAG;
    wire sel_en = BUS_REQ.addr == `TCC_OFF_IRQ_EN;

    wire [`TCC_DW-1:0] rd_mux =
        sel_cnt ? T2_COUNT :
        sel_capa ? cap_val_a :
        sel_capb ? cap_val_b :
        sel_cmpa ? cmp_thr_a :
        sel_cmpb ? cmp_thr_b :
        sel_cmpcfga ? cmp_word(cmp_cfg_a) :
        sel_cmpcfgb ? cmp_word(cmp_cfg_b) :
        sel_capcfga ? cap_word(cap_cfg_a) :
        sel_capcfgb ? cap_word(cap_cfg_b) :
        sel_flag ? irq_flag :
        sel_en ? irq_en : `TCC_RST_WORD;

    // ****************************************
    // compare channels
    // ****************************************
    wire match_a = cmp_hit(T2_COUNT, prev_count, cmp_thr_a);
    wire match_b = cmp_hit(T2_COUNT, prev_count, cmp_thr_b);
    wire next_lev_a = next_level(cmp_cfg_a.mode, lev_a, match_a);
    wire next_lev_b = next_level(cmp_cfg_b.mode, lev_b, match_b);

    // ****************************************
    // capture channels
    // ****************************************
    tcc_capture #(.FILT_LEN(FILT_LEN)) u_cap_a (
        .clk(CLK),
        .rst_b(RST_B),
        .pin(CAPA_IN),
        .cfg(cap_cfg_a),
        .count(T2_COUNT),
        .value(cap_val_a),
        .event_pulse(capa_evt)
    );

    tcc_capture #(.FILT_LEN(FILT_LEN)) u_cap_b (
        .clk(CLK),
        .rst_b(RST_B),
        .pin(CAPB_IN),
        .cfg(cap_cfg_b),
        .count(T2_COUNT),
        .value(cap_val_b),
        .event_pulse(capb_evt)
    );

    // ****************************************
    // event flags and request
    // ****************************************
    logic [`TCC_T2_EVT_HI-`TCC_T2_EVT_LO:0] t2_evt;
    always_comb
    begin
        t2_evt = '0;
        t2_evt[`TCC_EV_OVF] = T2_CORE_EVENTS.overflow;
        t2_evt[`TCC_EV_CMPA] = match_a;
        t2_evt[`TCC_EV_CMPB] = match_b;
        t2_evt[`TCC_EV_ZERO] = T2_CORE_EVENTS.zero;
        t2_evt[`TCC_EV_TOP] = T2_CORE_EVENTS.top;
        t2_evt[`TCC_EV_CAPA] = capa_evt;
        t2_evt[`TCC_EV_CAPB] = capb_evt;
    end

    wire [`TCC_DW-1:0] evt_set = {1'b0, t2_evt, 1'b0, T1_EVENTS};
    wire [`TCC_DW-1:0] evt_clr = (wr && sel_flag) ? wd : `TCC_RST_WORD;
    // set wins over a write-one-to-clear in the same cycle
    wire [`TCC_DW-1:0] next_irq_flag = ((irq_flag & ~evt_clr) | evt_set) & `TCC_EVT_MASK;

    assign IRQ = |(irq_flag & irq_en);

    // ****************************************
    // register updates
    // ****************************************
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cmp_thr_a <= `TCC_RST_WORD;
            cmp_thr_b <= `TCC_RST_WORD;
            cmp_cfg_a <= '0;
            cmp_cfg_b <= '0;
            cap_cfg_a <= '0;
            cap_cfg_b <= '0;
            irq_en <= `TCC_RST_WORD;
            irq_flag <= `TCC_RST_WORD;
        end
        else
        begin
            cmp_thr_a <= (wr && sel_cmpa) ? wd : cmp_thr_a;
            cmp_thr_b <= (wr && sel_cmpb) ? wd : cmp_thr_b;
            cmp_cfg_a <= (wr && sel_cmpcfga) ? cmp_cfg_of(wd) : cmp_cfg_a;
            cmp_cfg_b <= (wr && sel_cmpcfgb) ? cmp_cfg_of(wd) : cmp_cfg_b;
            cap_cfg_a <= (wr && sel_capcfga) ? cap_cfg_of(wd) : cap_cfg_a;
            cap_cfg_b <= (wr && sel_capcfgb) ? cap_cfg_of(wd) : cap_cfg_b;
            irq_en <= (wr && sel_en) ? (wd & `TCC_EVT_MASK) : irq_en;
            irq_flag <= next_irq_flag;
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            prev_count <= `TCC_RST_WORD;
            lev_a <= 1'b0;
            lev_b <= 1'b0;
            CMPA_PIN <= '{out: 1'b0, oe_b: 1'b1};
            CMPB_PIN <= '{out: 1'b0, oe_b: 1'b1};
        end
        else
        begin
            prev_count <= T2_COUNT;
            lev_a <= next_lev_a;
            lev_b <= next_lev_b;
            CMPA_PIN <= '{out: next_lev_a ^ cmp_cfg_a.inv, oe_b: !cmp_cfg_a.en};
            CMPB_PIN <= '{out: next_lev_b ^ cmp_cfg_b.inv, oe_b: !cmp_cfg_b.en};
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            BUS_RDATA <= `TCC_RST_WORD;
            T2_COUNT_LOAD <= 1'b0;
            T2_COUNT_LOAD_VALUE <= `TCC_RST_WORD;
        end
        else
        begin
            BUS_RDATA <= BUS_REQ.rd ? rd_mux : `TCC_RST_WORD;
            T2_COUNT_LOAD <= wr && sel_cnt;
            T2_COUNT_LOAD_VALUE <= (wr && sel_cnt) ? wd : T2_COUNT_LOAD_VALUE;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_cnt_write;
        wr && sel_cnt;
    endsequence

    sequence s_cnt_loaded;
        T2_COUNT_LOAD && (T2_COUNT_LOAD_VALUE == $past(wd));
    endsequence

    a_count_write_load: assert property (@(posedge CLK) disable iff (!RST_B)
        s_cnt_write ##1 !(wr && sel_cnt) |-> s_cnt_loaded ##1 !T2_COUNT_LOAD)
        else $error("count overwrite not passed to the counter");

    a_cmp_drive_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        !cmp_cfg_a.en |=> CMPA_PIN.oe_b)
        else $error("compare A pin driven while disabled");

    a_cmp_invert_out: assert property (@(posedge CLK) disable iff (!RST_B)
        1'b1 |=> (CMPB_PIN.out == (lev_b ^ $past(cmp_cfg_b.inv))))
        else $error("compare B polarity wrong");

    a_cmp_toggle_mode: assert property (@(posedge CLK) disable iff (!RST_B)
        (match_a && (cmp_cfg_a.mode == TCC_MODE_TOGGLE)) |=> (lev_a != $past(lev_a)))
        else $error("compare A toggle mode did not toggle");

    a_thr_write_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        (wr && sel_cmpa) |=> (cmp_thr_a == $past(wd)))
        else $error("compare A threshold not stored");

    a_thr_idle_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        !(wr && sel_cmpb) |=> (cmp_thr_b == $past(cmp_thr_b)))
        else $error("compare B threshold moved without a write");

    a_t2_event_gated: assert property (@(posedge CLK) disable iff (!RST_B)
        (capa_evt && irq_en[`TCC_T2_EVT_LO + `TCC_EV_CAPA] && !(wr && sel_en)) |=> IRQ)
        else $error("timer 2 capture A event did not raise the request");

    a_t1_event_gated: assert property (@(posedge CLK) disable iff (!RST_B)
        (T1_EVENTS[`TCC_EV_OVF] && irq_en[`TCC_T1_EVT_LO + `TCC_EV_OVF] && !(wr && sel_en)) |=> IRQ)
        else $error("timer 1 overflow event did not raise the request");

    a_flag_set_wins: assert property (@(posedge CLK) disable iff (!RST_B)
        T1_EVENTS[`TCC_EV_CMPB] |=> irq_flag[`TCC_T1_EVT_LO + `TCC_EV_CMPB])
        else $error("event lost its pending flag");

    a_flag_clear_gone: assert property (@(posedge CLK) disable iff (!RST_B)
        (wr && sel_flag && wd[`TCC_T1_EVT_LO + `TCC_EV_OVF] && !T1_EVENTS[`TCC_EV_OVF])
        |=> !irq_flag[`TCC_T1_EVT_LO + `TCC_EV_OVF])
        else $error("pending flag survived its clear");

    a_irq_quiet_masked: assert property (@(posedge CLK) disable iff (!RST_B)
        ((irq_flag & irq_en) == `TCC_RST_WORD) |-> !IRQ)
        else $error("request high with no enabled pending flag");

endmodule : tcc_top
